// [include/afs_map.svh]
`ifndef AFS_MAP_SVH
`define AFS_MAP_SVH
// ==========================================
// Register offsets
`define AFS_A_T2_GF   8'h00
`define AFS_A_T4_GF   8'h04
`define AFS_A_T2_BF   8'h08
`define AFS_A_T2_BP   8'h0C
`define AFS_A_T2_GP   8'h10
`define AFS_A_T4_BF   8'h14
`define AFS_A_T4_BP   8'h18
`define AFS_A_T4_GP   8'h1C
`define AFS_A_CFG     8'h20
`define AFS_A_HSLIM   8'h24
`define AFS_A_ACCREF  8'h28
`define AFS_A_CAL     8'h2C
`define AFS_A_STAT    8'h30
// ==========================================
// Config bit positions
`define AFS_B_UNIT    0
`define AFS_B_T2_10V  1
`define AFS_B_T4_VOLT 2
`define AFS_B_T4_10V  3
`define AFS_B_T4_SEL  4
// ==========================================
// Reset values and limits (0.01 Hz, 0.1 %)
`define AFS_F_GAIN_RST 16'h1770
`define AFS_F_MAX      16'h9C40
`define AFS_F_HS_RST   16'h2EE0
`define AFS_P_T4B_RST  12'h0C8
`define AFS_P_GAIN_RST 12'h3E8
`define AFS_P_MAX      12'hBB8
`define AFS_P_MIN_GAP  12'h032
`define AFS_DIV_STEPS  5'h1C
`endif

// [include/afs_pkg.sv]
// ==========================================
// Shared types
package afs_pkg;
  // Input range of a terminal
  typedef enum logic [1:0] {RNG_5V, RNG_10V, RNG_20MA} afs_rng_t;
  // Calibration method code
  typedef enum logic [1:0] {CAL_NONE, CAL_APPLIED, CAL_ENTERED, CAL_FREQ} afs_cal_t;
  // Conversion sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_OUT} afs_state_t;
endpackage : afs_pkg

// [hdl/afs_sync.sv]
`timescale 1ns/1ps
// ==========================================
// Two-flop synchroniser for a pin level
module afs_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_r; // First stage, read only by q

  // Plain shift through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : afs_sync

// [hdl/afs_div.sv]
`timescale 1ns/1ps
`include "afs_map.svh"
// ==========================================
// Restoring divider, one quotient bit a clock
module afs_div (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [27:0] num,
  input  wire logic [11:0] den,
  output logic             done,
  output logic [27:0]      quo
);
  logic [11:0] rem_r; // Partial remainder
  logic [11:0] den_r; // Divisor held for the run
  logic [4:0]  cnt_r; // Steps left
  logic [12:0] sh;    // Shifted remainder

  assign sh = {rem_r, quo[27]};

  // Shift-subtract loop; done pulses on the last step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r <= 12'h000;
      den_r <= 12'h000;
      cnt_r <= 5'h00;
      quo   <= 28'h0000000;
      done  <= 1'b0;
    end else if (start) begin
      rem_r <= 12'h000;
      den_r <= den;
      cnt_r <= `AFS_DIV_STEPS;
      quo   <= num;
      done  <= 1'b0;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
      done  <= (cnt_r == 5'h01);
      if (sh >= {1'b0, den_r}) begin
        rem_r <= 12'(sh - {1'b0, den_r});
        quo   <= {quo[26:0], 1'b1};
      end else begin
        rem_r <= sh[11:0];
        quo   <= {quo[26:0], 1'b0};
      end
    end else begin
      done <= 1'b0;
    end
  end
endmodule : afs_div

// [hdl/afs_scaler.sv]
`timescale 1ns/1ps
`include "afs_map.svh"
module afs_scaler (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic [11:0] T2_LEVEL,
  input  wire logic [11:0] T4_LEVEL,
  input  wire logic        START,
  output logic             RUN,
  output logic      [15:0] FREQ_CMD
);
  // ==========================================
  // Helpers
  // Stored 0.1 % to display units
  function automatic logic [15:0] to_disp(input logic [11:0] p, input afs_pkg::afs_rng_t r);
    unique case (r)
      afs_pkg::RNG_5V:  to_disp = {5'h00, p[11:1]};
      afs_pkg::RNG_10V: to_disp = {4'h0, p};
      default:          to_disp = {3'h0, p, 1'b0};
    endcase
  endfunction : to_disp

  // Display units back to 0.1 %, saturated
  function automatic logic [11:0] from_disp(input logic [15:0] v, input afs_pkg::afs_rng_t r);
    logic [16:0] w;
    w = 17'h00000;
    unique case (r)
      afs_pkg::RNG_5V:  w = {v, 1'b0};
      afs_pkg::RNG_10V: w = {1'b0, v};
      default:          w = {2'h0, v[15:1]};
    endcase
    from_disp = (w > {5'h00, `AFS_P_MAX}) ? `AFS_P_MAX : w[11:0];
  endfunction : from_disp

  // Frequency entry saturated at 400 Hz
  function automatic logic [15:0] sat_f(input logic [15:0] v);
    sat_f = (v > `AFS_F_MAX) ? `AFS_F_MAX : v;
  endfunction : sat_f

  // ==========================================
  // Registers
  logic [15:0] t2_gain_frequency_r;   // Gain freq, 0.01 Hz
  logic [15:0] t4_gain_frequency_r;
  logic [15:0] t2_bias_frequency_r;
  logic [15:0] t4_bias_frequency_r;
  logic [11:0] t2_bias_input_pct_r;   // Points, 0.1 %
  logic [11:0] t2_gain_input_pct_r;
  logic [11:0] t4_bias_input_pct_r;
  logic [11:0] t4_gain_input_pct_r;
  logic [4:0]  cfg_r;                 // Unit, ranges, select
  logic [15:0] high_speed_freq_limit_r;
  logic [15:0] accel_decel_ref_freq_r;
  logic        cal_err_r;             // Too-close entry seen
  logic        recal_r;               // T4 type changed
  logic        run_s;                 // Synchronised start

  afs_pkg::afs_rng_t rng2, rng4;      // Active ranges
  assign rng2 = cfg_r[`AFS_B_T2_10V] ? afs_pkg::RNG_10V : afs_pkg::RNG_5V;
  assign rng4 = !cfg_r[`AFS_B_T4_VOLT] ? afs_pkg::RNG_20MA :
                (cfg_r[`AFS_B_T4_10V] ? afs_pkg::RNG_10V : afs_pkg::RNG_5V);

  // ==========================================
  // Write decode: point and frequency requests
  afs_pkg::afs_cal_t cal_m;
  logic        pw_en;      // Point percent write
  logic        pw_t4;      // Terminal 4 target
  logic        pw_gain;    // Gain point target
  logic [11:0] pw_val;     // New point, 0.1 %
  logic [11:0] pw_other;   // Opposite point of same terminal
  logic        pw_ok;      // Gap wide enough
  logic        fw_en;      // Frequency write
  logic        fw_t4;
  logic        fw_gain;
  logic [15:0] fw_val;
  logic [11:0] gap;

  assign cal_m = afs_pkg::afs_cal_t'(WDATA[1:0]);

  // Requests from direct writes and from calibration
  always_comb begin
    pw_en   = 1'b0;
    pw_t4   = 1'b0;
    pw_gain = 1'b0;
    pw_val  = 12'h000;
    fw_en   = 1'b0;
    fw_t4   = 1'b0;
    fw_gain = 1'b0;
    fw_val  = sat_f(WDATA[15:0]);
    if (WR) begin
      unique case (ADDR)
        `AFS_A_T2_GF: begin fw_en = 1'b1; fw_gain = 1'b1; end
        `AFS_A_T4_GF: begin fw_en = 1'b1; fw_gain = 1'b1; fw_t4 = 1'b1; end
        `AFS_A_T2_BF: fw_en = 1'b1;
        `AFS_A_T4_BF: begin fw_en = 1'b1; fw_t4 = 1'b1; end
        `AFS_A_T2_BP, `AFS_A_T2_GP, `AFS_A_T4_BP, `AFS_A_T4_GP: begin
          pw_en   = 1'b1;
          pw_t4   = (ADDR == `AFS_A_T4_BP) || (ADDR == `AFS_A_T4_GP);
          pw_gain = (ADDR == `AFS_A_T2_GP) || (ADDR == `AFS_A_T4_GP);
          // Entry taken in the unit currently displayed
          pw_val  = cfg_r[`AFS_B_UNIT] ? from_disp(WDATA[15:0], pw_t4 ? rng4 : rng2)
                                       : from_disp(WDATA[15:0], afs_pkg::RNG_10V);
        end
        `AFS_A_CAL: begin
          // Applied input, entered value, or frequency only
          pw_t4   = WDATA[2];
          pw_gain = WDATA[3];
          fw_t4   = WDATA[2];
          fw_gain = WDATA[3];
          fw_val  = sat_f(WDATA[31:16]);
          unique case (cal_m)
            afs_pkg::CAL_APPLIED: begin
              pw_en  = 1'b1;
              pw_val = from_disp({4'h0, WDATA[2] ? T4_LEVEL : T2_LEVEL}, afs_pkg::RNG_10V);
            end
            afs_pkg::CAL_ENTERED: begin
              pw_en  = 1'b1;
              pw_val = cfg_r[`AFS_B_UNIT] ? from_disp(WDATA[31:16], WDATA[2] ? rng4 : rng2)
                                          : from_disp(WDATA[31:16], afs_pkg::RNG_10V);
            end
            afs_pkg::CAL_FREQ: fw_en = 1'b1;
            afs_pkg::CAL_NONE: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // Opposite point and distance check
  always_comb begin
    unique case ({pw_t4, pw_gain})
      2'b00:   pw_other = t2_gain_input_pct_r;
      2'b01:   pw_other = t2_bias_input_pct_r;
      2'b10:   pw_other = t4_gain_input_pct_r;
      default: pw_other = t4_bias_input_pct_r;
    endcase
    gap   = (pw_val > pw_other) ? (pw_val - pw_other) : (pw_other - pw_val);
    pw_ok = (gap >= `AFS_P_MIN_GAP);
  end

  // ==========================================
  // Point percentages; a rejected entry keeps the old value
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      t2_bias_input_pct_r <= 12'h000;
      t2_gain_input_pct_r <= `AFS_P_GAIN_RST;
      t4_bias_input_pct_r <= `AFS_P_T4B_RST;
      t4_gain_input_pct_r <= `AFS_P_GAIN_RST;
    end else if (pw_en && pw_ok) begin
      unique case ({pw_t4, pw_gain})
        2'b00:   t2_bias_input_pct_r <= pw_val;
        2'b01:   t2_gain_input_pct_r <= pw_val;
        2'b10:   t4_bias_input_pct_r <= pw_val;
        default: t4_gain_input_pct_r <= pw_val;
      endcase
    end
  end

  // Point frequencies; only the addressed one moves
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      t2_gain_frequency_r <= `AFS_F_GAIN_RST;
      t4_gain_frequency_r <= `AFS_F_GAIN_RST;
      t2_bias_frequency_r <= 16'h0000;
      t4_bias_frequency_r <= 16'h0000;
    end else if (fw_en) begin
      unique case ({fw_t4, fw_gain})
        2'b00:   t2_bias_frequency_r <= fw_val;
        2'b01:   t2_gain_frequency_r <= fw_val;
        2'b10:   t4_bias_frequency_r <= fw_val;
        default: t4_gain_frequency_r <= fw_val;
      endcase
    end
  end

  // Config, high-speed limit and accel reference; point writes never touch these
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r                   <= 5'h00;
      high_speed_freq_limit_r <= `AFS_F_HS_RST;
      accel_decel_ref_freq_r  <= `AFS_F_GAIN_RST;
    end else if (WR) begin
      if (ADDR == `AFS_A_CFG)
        cfg_r <= WDATA[4:0];
      if (ADDR == `AFS_A_HSLIM)
        high_speed_freq_limit_r <= sat_f(WDATA[15:0]);
      if (ADDR == `AFS_A_ACCREF)
        accel_decel_ref_freq_r <= sat_f(WDATA[15:0]);
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cal_err_r <= 1'b0;
      recal_r   <= 1'b0;
    end else begin
      if (pw_en && !pw_ok)
        cal_err_r <= 1'b1;
      else if (WR && ADDR == `AFS_A_STAT && WDATA[0])
        cal_err_r <= 1'b0;
      if (WR && ADDR == `AFS_A_CFG && WDATA[`AFS_B_T4_VOLT] != cfg_r[`AFS_B_T4_VOLT])
        recal_r <= 1'b1;
      else if (pw_en && pw_ok && pw_t4)
        recal_r <= 1'b0;
    end
  end

  // ==========================================
  // Read port; data stands only in the cycle after the strobe
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h00000000;
    end else if (!RD) begin
      RDATA <= 32'h00000000;
    end else begin
      unique case (ADDR)
        `AFS_A_T2_GF:  RDATA <= {16'h0000, t2_gain_frequency_r};
        `AFS_A_T4_GF:  RDATA <= {16'h0000, t4_gain_frequency_r};
        `AFS_A_T2_BF:  RDATA <= {16'h0000, t2_bias_frequency_r};
        `AFS_A_T4_BF:  RDATA <= {16'h0000, t4_bias_frequency_r};
        `AFS_A_T2_BP:  RDATA <= {16'h0000, cfg_r[`AFS_B_UNIT] ? to_disp(t2_bias_input_pct_r, rng2)
                                                           : {4'h0, t2_bias_input_pct_r}};
        `AFS_A_T2_GP:  RDATA <= {16'h0000, cfg_r[`AFS_B_UNIT] ? to_disp(t2_gain_input_pct_r, rng2)
                                                           : {4'h0, t2_gain_input_pct_r}};
        `AFS_A_T4_BP:  RDATA <= {16'h0000, cfg_r[`AFS_B_UNIT] ? to_disp(t4_bias_input_pct_r, rng4)
                                                           : {4'h0, t4_bias_input_pct_r}};
        `AFS_A_T4_GP:  RDATA <= {16'h0000, cfg_r[`AFS_B_UNIT] ? to_disp(t4_gain_input_pct_r, rng4)
                                                           : {4'h0, t4_gain_input_pct_r}};
        `AFS_A_CFG:    RDATA <= {27'h0000000, cfg_r};
        `AFS_A_HSLIM:  RDATA <= {16'h0000, high_speed_freq_limit_r};
        `AFS_A_ACCREF: RDATA <= {16'h0000, accel_decel_ref_freq_r};
        `AFS_A_STAT:   RDATA <= {FREQ_CMD, 13'h0000, run_s, recal_r, cal_err_r};
        default:       RDATA <= 32'h00000000; // Unmapped reads zero
      endcase
    end
  end

  // ==========================================
  // Start pin and run output
  afs_sync u_start (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .d     (START),
    .q     (run_s)
  );
  // Run follows start alone; the command already holds the bias frequency
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N)
      RUN <= 1'b0;
    else
      RUN <= run_s;
  end

  // ==========================================
  // Conversion: f = fb + (fg - fb) * (x - xb) / (xg - xb)
  afs_pkg::afs_state_t st_r;
  logic               sel4;
  logic signed [12:0] xd, den;   // Input and span offsets
  logic signed [16:0] fd;        // Frequency span
  logic        [27:0] num;       // |fd| * |xd|
  logic        [27:0] quo;
  logic               div_go, div_done;
  logic               neg_r;     // Sign of the slope term
  logic        [15:0] fb_r;      // Bias frequency held for the run
  logic signed [29:0] res;

  assign sel4 = cfg_r[`AFS_B_T4_SEL];
  assign xd   = sel4 ? 13'(signed'({1'b0, T4_LEVEL}) - signed'({1'b0, t4_bias_input_pct_r}))
                     : 13'(signed'({1'b0, T2_LEVEL}) - signed'({1'b0, t2_bias_input_pct_r}));
  assign den  = sel4 ? 13'(signed'({1'b0, t4_gain_input_pct_r}) - signed'({1'b0, t4_bias_input_pct_r}))
                     : 13'(signed'({1'b0, t2_gain_input_pct_r}) - signed'({1'b0, t2_bias_input_pct_r}));
  assign fd   = sel4 ? 17'(signed'({1'b0, t4_gain_frequency_r}) - signed'({1'b0, t4_bias_frequency_r}))
                     : 17'(signed'({1'b0, t2_gain_frequency_r}) - signed'({1'b0, t2_bias_frequency_r}));
  assign num  = 28'((fd[16] ? 17'(-fd) : fd) * (xd[12] ? 13'(-xd) : xd));
  assign div_go = (st_r == afs_pkg::ST_IDLE) && (den != 13'sh0000);
  assign res  = neg_r ? 30'(signed'({14'h0000, fb_r}) - signed'({2'h0, quo}))
                      : 30'(signed'({14'h0000, fb_r}) + signed'({2'h0, quo}));

  afs_div u_div (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .start (div_go),
    .num   (num),
    .den   (12'(den[12] ? 13'(-den) : den)),
    .done  (div_done),
    .quo   (quo)
  );

  // Sequencer: recompute continuously; a zero span holds the last command
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r  <= afs_pkg::ST_IDLE;
      neg_r <= 1'b0;
      fb_r  <= 16'h0000;
    end else begin
      unique case (st_r)
        afs_pkg::ST_IDLE: if (div_go) begin
          neg_r <= fd[16] ^ xd[12] ^ den[12];
          fb_r  <= sel4 ? t4_bias_frequency_r : t2_bias_frequency_r;
          st_r  <= afs_pkg::ST_DIV;
        end
        afs_pkg::ST_DIV:  if (div_done) st_r <= afs_pkg::ST_OUT;
        afs_pkg::ST_OUT:  st_r <= afs_pkg::ST_IDLE;
        default:          st_r <= afs_pkg::ST_IDLE;
      endcase
    end
  end

  // Clamp extrapolation below zero and above the high-speed limit
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N)
      FREQ_CMD <= 16'h0000;
    else if (st_r == afs_pkg::ST_OUT) begin
      if (res[29])
        FREQ_CMD <= 16'h0000;
      else if (res > signed'({14'h0000, high_speed_freq_limit_r}))
        FREQ_CMD <= high_speed_freq_limit_r;
      else
        FREQ_CMD <= res[15:0];
    end
  end

  // ==========================================
  // Checks
  cmd_limit_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (st_r == afs_pkg::ST_OUT) |=> FREQ_CMD <= $past(high_speed_freq_limit_r))
    else $error("command above high-speed limit");
  freq_range_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (WR && ADDR == `AFS_A_T2_GF) |=> t2_gain_frequency_r <= `AFS_F_MAX)
    else $error("gain frequency beyond 400 Hz");
  pct_range_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    t4_gain_input_pct_r <= `AFS_P_MAX && t2_bias_input_pct_r <= `AFS_P_MAX)
    else $error("point beyond 300 percent");
  gain_only_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (WR && ADDR == `AFS_A_T2_GF) |=> $stable(t2_bias_input_pct_r) && $stable(t2_gain_input_pct_r)
      && $stable(t2_bias_frequency_r))
    else $error("gain frequency write moved another point");
  accref_keep_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (WR && (ADDR == `AFS_A_T2_GP || ADDR == `AFS_A_T4_GP)) |=> $stable(accel_decel_ref_freq_r))
    else $error("gain point write moved accel reference");
  close_reject_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (pw_en && !pw_ok && !pw_t4 && !pw_gain) |=> cal_err_r && $stable(t2_bias_input_pct_r))
    else $error("close point not rejected");
  disp_pct_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (RD && ADDR == `AFS_A_T2_GP && !cfg_r[`AFS_B_UNIT] && !WR)
      |=> RDATA == {20'h00000, $past(t2_gain_input_pct_r)})
    else $error("percent readback wrong");
  div_time_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    div_go |-> ##30 (st_r == afs_pkg::ST_OUT))
    else $error("conversion took wrong time");
  bias_out_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (st_r == afs_pkg::ST_OUT && quo == 28'h0000000 && fb_r <= high_speed_freq_limit_r)
      |=> FREQ_CMD == $past(fb_r))
    else $error("bias frequency not commanded");
endmodule : afs_scaler

// [tb/afs_src_model.sv]
`timescale 1ns/1ps
// ==========================================
// Far side: analog source with sampling converter
module afs_src_model (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [15:0]       phys,  // Millivolts, or microamps in current mode
  input  wire afs_pkg::afs_rng_t rng,   // Range chosen on the panel
  output logic      [11:0]       level  // 0.1 % of full scale
);
  // Converter updates once a clock, so the level always lags the source by one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 12'h000;
    end else begin
      case (rng)
        afs_pkg::RNG_5V:  level <= 12'(phys / 16'h0005);
        afs_pkg::RNG_10V: level <= 12'(phys / 16'h000A);
        default:          level <= 12'(phys / 16'h0014); // 20 mA is full scale
      endcase
    end
  end
endmodule : afs_src_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "afs_map.svh"
// ==========================================
// Bench top
module tb_top;
  // Row: bias f, gain f, bias pct, gain pct, source mV, limit, expected command
  typedef struct packed {logic [15:0] bf, gf, bp, gp, mv, lim, exp;} afs_row_t;
  localparam afs_row_t ROWS [8] = '{
    '{16'h0000, 16'h1770, 16'h0000, 16'h03E8, 16'h09C4, 16'h2EE0, 16'h0BB8},
    '{16'h0000, 16'h1770, 16'h0000, 16'h03E8, 16'h1388, 16'h2EE0, 16'h1770},
    '{16'h03E8, 16'h1770, 16'h0000, 16'h03E8, 16'h0000, 16'h2EE0, 16'h03E8},
    '{16'h03E8, 16'h1388, 16'h0000, 16'h03E8, 16'h1388, 16'h2EE0, 16'h1388},
    '{16'h0000, 16'h1770, 16'h00C8, 16'h0320, 16'h09C4, 16'h2EE0, 16'h0BB8},
    '{16'h0000, 16'h1770, 16'h00C8, 16'h0320, 16'h0000, 16'h2EE0, 16'h0000},
    '{16'h0000, 16'h4E20, 16'h0000, 16'h03E8, 16'h1388, 16'h2EE0, 16'h2EE0},
    '{16'h0000, 16'h4E20, 16'h0000, 16'h03E8, 16'h1388, 16'h4E20, 16'h4E20}};
  // Reset values of offsets 00 to 2C
  localparam logic [15:0] RSTV [12] = '{16'h1770, 16'h1770, 16'h0000, 16'h0000, 16'h03E8, 16'h0000,
    16'h00C8, 16'h03E8, 16'h0000, 16'h2EE0, 16'h1770, 16'h0000};
  logic        SYS_CLK, RST_N, WR, RD, START, RUN;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [11:0] T2_LEVEL, T4_LEVEL;
  logic [15:0] FREQ_CMD, t2_phys, t4_phys; // Source values in mV / uA
  int          fails, checks;

  afs_scaler dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .T2_LEVEL(T2_LEVEL), .T4_LEVEL(T4_LEVEL), .START(START), .RUN(RUN), .FREQ_CMD(FREQ_CMD));
  afs_src_model src2 (.clk(SYS_CLK), .rst_n(RST_N), .phys(t2_phys), .rng(afs_pkg::RNG_5V), .level(T2_LEVEL));
  afs_src_model src4 (.clk(SYS_CLK), .rst_n(RST_N), .phys(t4_phys), .rng(afs_pkg::RNG_20MA), .level(T4_LEVEL));

  // ==========================================
  // Clock, 20 ns period
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  // ==========================================
  // Compare and report
  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_reg

  task chk_pin(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_pin

  task tally_and_finish();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // Register bus: one-cycle strobes, data the cycle after a read
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge SYS_CLK);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask : wr

  // Read, mask off fields that are not under test, compare
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
    chk_reg(d & m, e);
  endtask : rdc

  // Conversion is free running; a run takes about 30 cycles, so 200 is ample
  task wait_freq(input logic [15:0] e);
    int n;
    n = 0;
    while (FREQ_CMD !== e && n < 200) begin
      @(posedge SYS_CLK);
      #1 n++;
    end
    chk_pin(FREQ_CMD, e);
    if (FREQ_CMD !== e) tally_and_finish();
  endtask : wait_freq

  // ==========================================
  // Main sequence
  initial begin
    {WR, RD, START, ADDR, WDATA, t2_phys, t4_phys, fails, checks} = '0;
    RST_N = 1'b0;
    repeat (3) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    // Table cases; points written bias before gain so the gap never closes
    for (int i = 0; i < 8; i++) begin
      wr(`AFS_A_HSLIM, 32'(ROWS[i].lim));
      wr(`AFS_A_T2_BF, 32'(ROWS[i].bf));
      wr(`AFS_A_T2_GF, 32'(ROWS[i].gf));
      wr(`AFS_A_T2_BP, 32'(ROWS[i].bp));
      wr(`AFS_A_T2_GP, 32'(ROWS[i].gp));
      t2_phys <= ROWS[i].mv;
      wait_freq(ROWS[i].exp);
    end
    // Reset in mid-run, then reset values and an unmapped place
    RST_N <= 1'b0;
    @(posedge SYS_CLK);
    #1 chk_pin(FREQ_CMD, 16'h0000);
    chk_pin({15'h0000, RUN}, 16'h0000);
    repeat (3) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 12; i++) rdc(8'(i * 4), 32'(RSTV[i]), 32'hFFFF_FFFF);
    rdc(8'h34, 32'h0000_0000, 32'hFFFF_FFFF);
    // Gap boundary: 49 refused and flagged, 50 taken
    wr(`AFS_A_T2_BP, 32'h0000_03B7);
    rdc(`AFS_A_T2_BP, 32'h0000_0000, 32'hFFFF_FFFF);
    rdc(`AFS_A_STAT, 32'h0000_0001, 32'h0000_0001);
    wr(`AFS_A_STAT, 32'h0000_0001);
    rdc(`AFS_A_STAT, 32'h0000_0000, 32'h0000_0001);
    wr(`AFS_A_T2_BP, 32'h0000_03B6);
    rdc(`AFS_A_T2_BP, 32'h0000_03B6, 32'hFFFF_FFFF);
    wr(`AFS_A_T2_BP, 32'h0000_0000);
    // Gain-only changes, saturation, reference untouched
    wr(`AFS_A_T2_GF, 32'h0000_FFFF);
    rdc(`AFS_A_T2_GF, 32'h0000_9C40, 32'hFFFF_FFFF);
    rdc(`AFS_A_T2_GP, 32'h0000_03E8, 32'hFFFF_FFFF);
    wr(`AFS_A_T2_GP, 32'h0000_0FFF);
    rdc(`AFS_A_T2_GP, 32'h0000_0BB8, 32'hFFFF_FFFF);
    rdc(`AFS_A_ACCREF, 32'h0000_1770, 32'hFFFF_FFFF);
    // Calibration: capture 4 V, entered bias 10 %, frequency-only gain
    t2_phys <= 16'h0FA0;
    wr(`AFS_A_CAL, 32'h0000_0009);
    rdc(`AFS_A_T2_GP, 32'h0000_0320, 32'hFFFF_FFFF);
    wr(`AFS_A_CAL, 32'h0064_0002);
    rdc(`AFS_A_T2_BP, 32'h0000_0064, 32'hFFFF_FFFF);
    wr(`AFS_A_CAL, 32'h1770_000B);
    rdc(`AFS_A_T2_GF, 32'h0000_1770, 32'hFFFF_FFFF);
    rdc(`AFS_A_T2_BF, 32'h0000_0000, 32'hFFFF_FFFF);
    wait_freq(16'h1770);
    // Display in volts and milliamps
    wr(`AFS_A_CFG, 32'h0000_0001);
    rdc(`AFS_A_T2_GP, 32'h0000_0190, 32'hFFFF_FFFF);
    rdc(`AFS_A_T4_GP, 32'h0000_07D0, 32'hFFFF_FFFF);
    rdc(`AFS_A_T4_BP, 32'h0000_0190, 32'hFFFF_FFFF);
    wr(`AFS_A_CFG, 32'h0000_0003);
    rdc(`AFS_A_T2_GP, 32'h0000_0320, 32'hFFFF_FFFF);
    // Entry in milliamps: 16.00 mA is 80 % of the current range
    wr(`AFS_A_CFG, 32'h0000_0001);
    wr(`AFS_A_T4_GP, 32'h0000_0640);
    rdc(`AFS_A_T4_GP, 32'h0000_0640, 32'hFFFF_FFFF);
    wr(`AFS_A_CFG, 32'h0000_0000);
    rdc(`AFS_A_T4_GP, 32'h0000_0320, 32'hFFFF_FFFF);
    wr(`AFS_A_T4_GP, 32'h0000_03E8);
    // Terminal 4 on current input
    wr(`AFS_A_CFG, 32'h0000_0010);
    t4_phys <= 16'h2EE0;
    wait_freq(16'h0BB8);
    t4_phys <= 16'h4E20;
    wait_freq(16'h1770);
    wr(`AFS_A_T4_BF, 32'h0000_03E8);
    t4_phys <= 16'h0FA0;
    wait_freq(16'h03E8);
    // Type switch asks for recalibration; a bias write answers it
    wr(`AFS_A_CFG, 32'h0000_0014);
    rdc(`AFS_A_STAT, 32'h0000_0002, 32'h0000_0002);
    wr(`AFS_A_T4_BP, 32'h0000_00C8);
    rdc(`AFS_A_STAT, 32'h0000_0000, 32'h0000_0002);
    // Start alone runs at the bias frequency
    wr(`AFS_A_CFG, 32'h0000_0000);
    wr(`AFS_A_T2_BP, 32'h0000_0000);
    wr(`AFS_A_T2_BF, 32'h0000_03E8);
    t2_phys <= 16'h0000;
    START   <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    #1 chk_pin({15'h0000, RUN}, 16'h0000);
    @(posedge SYS_CLK);
    #1 chk_pin({15'h0000, RUN}, 16'h0001);
    wait_freq(16'h03E8);
    tally_and_finish();
  end
endmodule : tb_top
